/* hw/adc_result_consts.svh */
// Purpose: offsets, field positions, reset values of the converter result/irq block
// Assumes: word-aligned classic wishbone, 32-bit data
// Notes: Behaviour list below
// Behaviour
// - last result holds bits 9:0 until next
// - channel result captures low ten bits
// - channel result updates only when enabled
// - enable write one sets mask bit
// - disable write one clears mask bit
// - mask register reads enabled sources, read-only
// - bits 7:0 eoc, 15:8 channel overrun
// - bits 16..19 ready, overrun, count, empty
// - ready flag set on result, cleared reading
// - channel overrun flag cleared by status read
// - any overrun flag cleared by status read
// - eoc reads one only enabled and complete
`ifndef ADC_RESULT_CONSTS_SVH
`define ADC_RESULT_CONSTS_SVH
`define OFS_CHAN_STATUS 8'h18
`define OFS_STATUS 8'h1c
`define OFS_LAST_RESULT 8'h20
`define OFS_IRQ_ENABLE 8'h24
`define OFS_IRQ_DISABLE 8'h28
`define OFS_IRQ_MASK 8'h2c
`define OFS_CHAN_RESULT0 8'h30
`define OFS_CHAN_RESULT7 8'h4c
`define POS_EOC 0
`define POS_OVR 8
`define POS_READY 16
`define POS_ANY_OVR 17
`define POS_RX_DONE 18
`define POS_RX_EMPTY 19
`define STATUS_BITS 20
`define RESET_WORD 32'h0000_0000
`endif

/* hw/adc_result_pkg.sv */
// Purpose: shared types of the converter result/irq block
// Assumes: ten-bit samples
// Notes: constants live in the header
package adc_result_pkg;
    typedef logic [9:0] sample_t;
    typedef logic [31:0] word_t;
endpackage

/* hw/chan_result_slot.sv */
// Purpose: one channel's result holder and eoc/overrun source
// Assumes: done strobe is one cycle, same clock
// Notes: overrun when a new result lands before the old was read
`timescale 1ns/1ps
module chan_result_slot
    import adc_result_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic enabled,
    input wire logic done,
    input wire sample_t sample,
    input wire logic read_result,
    output sample_t value,
    output logic eoc,
    output logic overrun_event
);
    logic fresh;

    always_ff @(posedge clk) begin
        if (reset) begin
            value <= '0;
        end else if (ce && done && enabled) begin
            value <= sample;
        end
    end

    // set wins over the clear by a read in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            fresh <= 1'b0;
        end else if (ce) begin
            if (done && enabled) begin
                fresh <= 1'b1;
            end else if (read_result || !enabled) begin
                fresh <= 1'b0;
            end
        end
    end

    assign eoc = fresh && enabled;
    assign overrun_event = done && enabled && fresh && !read_result;
endmodule // chan_result_slot

/* hw/adc_result_regs.sv */
// Purpose: result, status and interrupt mask registers of an 8-channel converter
// Assumes: classic wishbone slave, ack one cycle after request, no wait
// Notes: unmapped addresses read zero and ignore writes; still acked
`timescale 1ns/1ps
`include "adc_result_consts.svh"
module adc_result_regs
    import adc_result_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] chan_enabled,
    input wire logic [7:0] conv_done,
    input wire logic [9:0] conv_sample,
    input wire logic rx_count_done,
    input wire logic rx_buffers_empty,
    output logic irq
);
    // the decode and the status layout are fixed at eight slots
    if (CHANNELS != 8) begin : g_bad_channels
        $error("adc_result_regs supports exactly eight channels");
    end

    sample_t latest_sample_value;
    sample_t chan_value [8];
    logic [7:0] eoc;
    logic [7:0] ovr_event;
    logic [7:0] read_chan;
    logic [7:0] channel_overrun_flag;
    logic result_ready_flag;
    logic any_overrun_flag;
    logic receive_count_done_flag;
    logic receive_buffers_empty_flag;
    logic [`STATUS_BITS-1:0] irq_mask;
    logic [`STATUS_BITS-1:0] status_word;
    logic [`STATUS_BITS-1:0] pending;
    logic req;
    logic wr;
    logic rd;
    logic sel_all;
    logic rd_status;
    logic rd_last;
    logic any_done;
    logic [31:0] next_dat;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign sel_all = wb_sel_i == 4'hf;
    assign wr = ce && req && wb_we_i && sel_all;
    assign rd = ce && req && !wb_we_i;
    assign rd_status = rd && wb_adr_i == `OFS_STATUS;
    assign rd_last = rd && wb_adr_i == `OFS_LAST_RESULT;
    assign any_done = |(conv_done & chan_enabled);

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_chan
            assign read_chan[g] = rd && wb_adr_i == (`OFS_CHAN_RESULT0 + 8'(4 * g));
            chan_result_slot u_slot (
                .clk(clk),
                .reset(reset),
                .ce(ce),
                .enabled(chan_enabled[g]),
                .done(conv_done[g]),
                .sample(conv_sample),
                .read_result(read_chan[g]),
                .value(chan_value[g]),
                .eoc(eoc[g]),
                .overrun_event(ovr_event[g])
            );
        end
    endgenerate

    // last result follows any completed conversion of an enabled channel
    always_ff @(posedge clk) begin
        if (reset) begin
            latest_sample_value <= '0;
        end else if (ce && any_done) begin
            latest_sample_value <= conv_sample;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_ready_flag <= 1'b0;
        end else if (ce && any_done) begin
            result_ready_flag <= 1'b1;
        end else if (rd_last) begin
            result_ready_flag <= 1'b0;
        end
    end

    // event in the clearing cycle survives the read
    always_ff @(posedge clk) begin
        if (reset) begin
            channel_overrun_flag <= '0;
            any_overrun_flag <= 1'b0;
        end else if (ce) begin
            channel_overrun_flag <= (rd_status ? 8'h00 : channel_overrun_flag)
                | ovr_event;
            any_overrun_flag <= (rd_status ? 1'b0 : any_overrun_flag)
                | (|ovr_event);
        end
    end

    // receive-side levels come from the same clock domain
    always_ff @(posedge clk) begin
        if (reset) begin
            receive_count_done_flag <= 1'b0;
            receive_buffers_empty_flag <= 1'b0;
        end else if (ce) begin
            receive_count_done_flag <= rx_count_done;
            receive_buffers_empty_flag <= rx_buffers_empty;
        end
    end

    assign status_word = {receive_buffers_empty_flag, receive_count_done_flag,
        any_overrun_flag, result_ready_flag, channel_overrun_flag, eoc};

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_mask <= '0;
        end else if (wr && wb_adr_i == `OFS_IRQ_ENABLE) begin
            irq_mask <= irq_mask | wb_dat_i[`STATUS_BITS-1:0];
        end else if (wr && wb_adr_i == `OFS_IRQ_DISABLE) begin
            irq_mask <= irq_mask & ~wb_dat_i[`STATUS_BITS-1:0];
        end
    end

    assign pending = status_word & irq_mask;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |pending;
        end
    end

    always_comb begin
        next_dat = `RESET_WORD;
        if (wb_adr_i >= `OFS_CHAN_RESULT0 && wb_adr_i <= `OFS_CHAN_RESULT7
            && wb_adr_i[1:0] == 2'b00) begin
            next_dat = {22'h0, chan_value[3'(wb_adr_i[4:2] - 3'h4)]};
        end else begin
            unique case (wb_adr_i)
                `OFS_CHAN_STATUS: next_dat = {24'h0, chan_enabled};
                `OFS_STATUS: next_dat = {12'h0, status_word};
                `OFS_LAST_RESULT: next_dat = {22'h0, latest_sample_value};
                `OFS_IRQ_MASK: next_dat = {12'h0, irq_mask};
                default: next_dat = `RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `RESET_WORD;
        end else if (ce) begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= next_dat;
            end
        end
    end

    // assertions
    property p_last_hold;
        @(posedge clk) disable iff (reset)
        ce && any_done |=> latest_sample_value == $past(conv_sample);
    endproperty
    a_last_hold: assert property (p_last_hold) else $error("last result not loaded");

    property p_last_stable;
        @(posedge clk) disable iff (reset)
        !any_done |=> $stable(latest_sample_value);
    endproperty
    a_last_stable: assert property (p_last_stable) else $error("last result moved");

    property p_disabled_chan;
        @(posedge clk) disable iff (reset)
        !chan_enabled[3] |=> $stable(chan_value[3]);
    endproperty
    a_disabled_chan: assert property (p_disabled_chan) else $error("chan 3 loaded");

    property p_chan_load;
        @(posedge clk) disable iff (reset)
        ce && conv_done[2] && chan_enabled[2] |=> chan_value[2] == $past(conv_sample);
    endproperty
    a_chan_load: assert property (p_chan_load) else $error("channel result missed");

    property p_enable;
        @(posedge clk) disable iff (reset)
        wr && wb_adr_i == `OFS_IRQ_ENABLE
            |=> (irq_mask & $past(wb_dat_i[19:0])) == $past(wb_dat_i[19:0]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not set mask");

    property p_disable;
        @(posedge clk) disable iff (reset)
        wr && wb_adr_i == `OFS_IRQ_DISABLE |=> (irq_mask & $past(wb_dat_i[19:0])) == 20'h0;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not clear mask");

    property p_ready_clear;
        @(posedge clk) disable iff (reset)
        rd_last && !any_done |=> !result_ready_flag;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

    property p_any_ovr;
        @(posedge clk) disable iff (reset)
        ce && (|ovr_event) |=> any_overrun_flag && channel_overrun_flag != 8'h00;
    endproperty
    a_any_ovr: assert property (p_any_ovr) else $error("overrun not flagged");

    property p_eoc;
        @(posedge clk) disable iff (reset)
        !chan_enabled[2] |-> !eoc[2];
    endproperty
    a_eoc: assert property (p_eoc) else $error("eoc on disabled channel");

    property p_irq;
        @(posedge clk) disable iff (reset)
        ce |=> irq == $past(|pending);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_ack_pulse;
        @(posedge clk) disable iff (reset)
        ce && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

    property p_ack_answer;
        @(posedge clk) disable iff (reset)
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

    property p_ack_idle;
        @(posedge clk) disable iff (reset)
        ce && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

    // a low enable must freeze every register, the bus answer included
    property p_freeze;
        @(posedge clk) disable iff (reset)
        !ce |=> $stable(irq_mask) && $stable(latest_sample_value) && $stable(result_ready_flag)
            && $stable(channel_overrun_flag) && $stable(wb_ack_o) && $stable(irq);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_mask_hold;
        @(posedge clk) disable iff (reset)
        !(wr && (wb_adr_i == `OFS_IRQ_ENABLE || wb_adr_i == `OFS_IRQ_DISABLE))
            |=> $stable(irq_mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed");

    property p_mask_read;
        @(posedge clk) disable iff (reset)
        rd && wb_adr_i == `OFS_IRQ_MASK |=> wb_dat_o == {12'h0, $past(irq_mask)};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

    property p_last_read;
        @(posedge clk) disable iff (reset)
        rd_last |=> wb_dat_o == {22'h0, $past(latest_sample_value)};
    endproperty
    a_last_read: assert property (p_last_read) else $error("last read wrong");

    property p_status_read;
        @(posedge clk) disable iff (reset)
        rd_status |=> wb_dat_o == {12'h0, $past(status_word)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_chan_read;
        @(posedge clk) disable iff (reset)
        read_chan[2] |=> wb_dat_o == {22'h0, $past(chan_value[2])};
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("chan read wrong");

    property p_unmapped;
        @(posedge clk) disable iff (reset)
        rd && wb_adr_i >= 8'h50 |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_ready_set;
        @(posedge clk) disable iff (reset)
        ce && any_done |=> result_ready_flag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_ovr_clear;
        @(posedge clk) disable iff (reset)
        rd_status && ovr_event == 8'h00 |=> channel_overrun_flag == 8'h00 && !any_overrun_flag;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

    property p_ovr_sticky;
        @(posedge clk) disable iff (reset)
        !rd_status
            |=> (channel_overrun_flag & $past(channel_overrun_flag)) == $past(channel_overrun_flag);
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("flag dropped");

    property p_any_ovr_match;
        @(posedge clk) disable iff (reset)
        channel_overrun_flag != 8'h00 |-> any_overrun_flag;
    endproperty
    a_any_ovr_match: assert property (p_any_ovr_match) else $error("flag mismatch");

    property p_chan_hold;
        @(posedge clk) disable iff (reset)
        !conv_done[2] |=> $stable(chan_value[2]);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("chan 2 moved");

    property p_eoc_set;
        @(posedge clk) disable iff (reset)
        ce && conv_done[2] && chan_enabled[2] |=> eoc[2] == chan_enabled[2];
    endproperty
    a_eoc_set: assert property (p_eoc_set) else $error("eoc not set");

    property p_eoc_clear;
        @(posedge clk) disable iff (reset)
        ce && read_chan[2] && !conv_done[2] |=> !eoc[2];
    endproperty
    a_eoc_clear: assert property (p_eoc_clear) else $error("eoc not cleared");

    property p_rx_flags;
        @(posedge clk) disable iff (reset)
        ce |=> receive_count_done_flag == $past(rx_count_done)
            && receive_buffers_empty_flag == $past(rx_buffers_empty);
    endproperty
    a_rx_flags: assert property (p_rx_flags) else $error("rx flags wrong");
endmodule // adc_result_regs

/* tb/testbench.sv */
// Purpose: self-checking bench for the converter result and irq registers
// Assumes: ack one cycle after a taken request, irq registered one cycle late
// Notes: ce dropped once to check freezing; the bench plays the converter side itself
`timescale 1ns/1ps
module testbench;
    import adc_result_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    word_t wb_dat_i = 32'h0;
    word_t wb_dat_o;
    logic wb_ack_o;
    logic [7:0] chan_enabled = 8'h00;
    logic [7:0] conv_done = 8'h00;
    sample_t conv_sample = 10'h000;
    logic rx_count_done = 1'b0;
    logic rx_buffers_empty = 1'b0;
    logic irq;
    int n_mismatch = 0;
    int total_checks = 0;
    word_t rd;

    always #20 clk = ~clk;

    adc_result_regs #(.CHANNELS(8)) dut_u (
        .clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_enabled(chan_enabled),
        .conv_done(conv_done), .conv_sample(conv_sample), .rx_count_done(rx_count_done),
        .rx_buffers_empty(rx_buffers_empty), .irq(irq));

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until ack is sampled high, then released for one cycle
    task automatic bus(input logic we, input logic [7:0] a, input word_t d,
                       input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input word_t d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rchk(input logic [7:0] a, input word_t exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(rd, exp);
    endtask

    // an input change needs one edge into the flag and one more into irq
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, {31'h0, e});
    endtask

    task automatic conv(input int ch, input sample_t s);
        conv_done <= 8'(8'h01 << ch);
        conv_sample <= s;
        @(posedge clk);
        conv_done <= 8'h00;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset;
        rchk(8'h20, 32'h0);
        rchk(8'h2c, 32'h0);
        rchk(8'h38, 32'h0);
        rchk(8'h1c, 32'h0);
        irq_chk(1'b0);
    endtask

    task automatic t_mask;
        wr(8'h24, 32'hffff_ffff);
        rchk(8'h2c, 32'h000f_ffff);
        wr(8'h28, 32'h0000_f00f);
        rchk(8'h2c, 32'h000f_0ff0);
        wr(8'h2c, 32'h0);
        rchk(8'h2c, 32'h000f_0ff0);
        bus(1'b1, 8'h24, 32'hffff_ffff, 4'h1);
        rchk(8'h2c, 32'h000f_0ff0);
        wr(8'h28, 32'hffff_ffff);
        rchk(8'h2c, 32'h0);
    endtask

    task automatic t_results;
        chan_enabled <= 8'h04;
        conv(2, 10'h2a5);
        rchk(8'h1c, 32'h0001_0004);
        rchk(8'h20, 32'h0000_02a5);
        rchk(8'h1c, 32'h0000_0004);
        rchk(8'h38, 32'h0000_02a5);
        rchk(8'h1c, 32'h0);
        // channel 3 stays disabled, so nothing may land anywhere
        conv(3, 10'h155);
        rchk(8'h3c, 32'h0);
        rchk(8'h20, 32'h0000_02a5);
        rchk(8'h1c, 32'h0);
    endtask

    task automatic t_overrun;
        conv(2, 10'h0ff);
        conv(2, 10'h300);
        rchk(8'h1c, 32'h0003_0404);
        rchk(8'h1c, 32'h0001_0004);
        rchk(8'h38, 32'h0000_0300);
        rchk(8'h20, 32'h0000_0300);
    endtask

    task automatic t_irq;
        wr(8'h24, 32'h0001_0000);
        irq_chk(1'b0);
        conv(2, 10'h1a5);
        irq_chk(1'b1);
        wr(8'h28, 32'h0001_0000);
        irq_chk(1'b0);
        wr(8'h24, 32'h0001_0000);
        irq_chk(1'b1);
        rchk(8'h20, 32'h0000_01a5);
        irq_chk(1'b0);
        rchk(8'h38, 32'h0000_01a5);
        wr(8'h28, 32'hffff_ffff);
    endtask

    task automatic t_rx;
        rx_count_done <= 1'b1;
        rx_buffers_empty <= 1'b1;
        wr(8'h24, 32'h0008_0000);
        irq_chk(1'b1);
        rchk(8'h1c, 32'h000c_0000);
        rx_count_done <= 1'b0;
        rx_buffers_empty <= 1'b0;
        irq_chk(1'b0);
        rchk(8'h60, 32'h0);
        wr(8'h20, 32'h0000_03ff);
        rchk(8'h20, 32'h0000_01a5);
    endtask

    // a conversion that ends while the enable is low must leave no trace
    task automatic t_freeze;
        ce <= 1'b0;
        conv(2, 10'h3c3);
        ce <= 1'b1;
        rchk(8'h20, 32'h0000_01a5);
        rchk(8'h38, 32'h0000_01a5);
        rchk(8'h1c, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_mask();
        t_results();
        t_overrun();
        t_irq();
        t_rx();
        t_freeze();
        final_report();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule // testbench
